/* pkg/dom_pkg.sv */
// Behaviour
// R1 - each output has function code; defaults 01,00,05
// R2 - eleven codes, twelve on variant models
// R3 - three monitors select seven quantities, default 00; voltage and current monitors give code 03 as invalid zero
// R4 - polarity 00 normally open, 01 inverts
// R5 - logic outputs reset to normally open
// R6 - relay polarity resets to normally closed
// R7 - code 00 asserts while running
// R8 - code 01 asserts at set frequency
// R9 - code 02 sets on accel threshold, clears decel
// R10 - code 06 asserts only at thresholds
// R11 - code 03 asserts above overload threshold
// R12 - code 04 asserts above pid deviation threshold
// R13 - code 05 asserts on alarm until reset
// R14 - alarm output low when no trip since reset
// R15 - codes 08, 09 assert on low supply
// R16 - code 11 asserts above run-time limit
// R17 - code 12 asserts above powered-time limit
// R18 - deviation threshold 0.0-100.0 percent, default 3.0
// R19 - arrival thresholds default 0.00 hertz
// R20 - undefined codes hold output inactive
// R21 - level recomputed every cycle through polarity
package dom_pkg;
   localparam int dom_aw = 4;
   localparam int dom_dw = 16;
   localparam int dom_freq_w = 16;
   // register indices
   localparam logic [3:0] dom_reg_out_a_fn = 4'h0;
   localparam logic [3:0] dom_reg_out_b_fn = 4'h1;
   localparam logic [3:0] dom_reg_relay_fn = 4'h2;
   localparam logic [3:0] dom_reg_pulse_sel = 4'h3;
   localparam logic [3:0] dom_reg_volt_sel = 4'h4;
   localparam logic [3:0] dom_reg_curr_sel = 4'h5;
   localparam logic [3:0] dom_reg_out_a_pol = 4'h6;
   localparam logic [3:0] dom_reg_out_b_pol = 4'h7;
   localparam logic [3:0] dom_reg_relay_pol = 4'h8;
   localparam logic [3:0] dom_reg_accel_thr = 4'h9;
   localparam logic [3:0] dom_reg_decel_thr = 4'ha;
   localparam logic [3:0] dom_reg_dev_thr = 4'hb;
   localparam logic [3:0] dom_reg_status = 4'hc;
   // reset values
   localparam logic [7:0] dom_rst_out_a_fn = 8'h01;
   localparam logic [7:0] dom_rst_out_b_fn = 8'h00;
   localparam logic [7:0] dom_rst_relay_fn = 8'h05;
   localparam logic [7:0] dom_rst_mon_sel = 8'h00;
   localparam logic [7:0] dom_pol_open = 8'h00;
   localparam logic [7:0] dom_pol_closed = 8'h01;
   localparam logic [15:0] dom_rst_arrival = 16'h0000;
   // deviation threshold in tenths of a percent
   localparam logic [15:0] dom_rst_dev_thr = 16'h001e;
   localparam logic [15:0] dom_dev_thr_max = 16'h03e8;
   // function codes
   localparam logic [7:0] dom_fn_run = 8'h00;
   localparam logic [7:0] dom_fn_arrival_constant_speed = 8'h01;
   localparam logic [7:0] dom_fn_arrival_over_frequency = 8'h02;
   localparam logic [7:0] dom_fn_overload_warning = 8'h03;
   localparam logic [7:0] dom_fn_pid_deviation = 8'h04;
   localparam logic [7:0] dom_fn_alarm = 8'h05;
   localparam logic [7:0] dom_fn_arrival_at_threshold = 8'h06;
   localparam logic [7:0] dom_fn_power_loss = 8'h08;
   localparam logic [7:0] dom_fn_undervoltage = 8'h09;
   localparam logic [7:0] dom_fn_run_time_over = 8'h0b;
   localparam logic [7:0] dom_fn_powered_time_over = 8'h0c;
   localparam logic [7:0] dom_fn_thermal = 8'h0d;
   // analog monitor codes
   localparam logic [7:0] dom_mon_freq = 8'h00;
   localparam logic [7:0] dom_mon_current = 8'h01;
   localparam logic [7:0] dom_mon_digital_freq = 8'h03;
   localparam logic [7:0] dom_mon_voltage = 8'h04;
   localparam logic [7:0] dom_mon_power = 8'h05;
   localparam logic [7:0] dom_mon_thermal = 8'h06;
   localparam logic [7:0] dom_mon_ramp_freq = 8'h07;
   // drive status conditions
   typedef struct packed {
      logic running;
      logic accelerating;
      logic decelerating;
      logic overload_warning;
      logic alarm_event;
      logic alarm_reset;
      logic power_loss_flag;
      logic undervoltage_flag;
      logic run_time_over;
      logic powered_time_over;
      logic thermal_over;
   } dom_status_t;
   typedef struct packed {
      logic [15:0] out_freq;
      logic [15:0] set_frequency;
      logic [15:0] pid_error;
      logic [15:0] out_current;
      logic [15:0] out_voltage;
      logic [15:0] in_power;
      logic [15:0] thermal_level;
      logic [15:0] ramp_freq;
   } dom_meas_t;
   typedef struct packed {
      logic [15:0] value;
      logic valid;
   } dom_mon_t;
endpackage

/* hdl/dom_out_sel.sv */
`timescale 1ns/100ps
module dom_out_sel (
   input wire logic [7:0] fn_code, // function code
   input wire logic [7:0] polarity, // polarity code
   input wire logic allow_thermal, // variant with twelfth code
   input wire logic [13:0] cond, // condition vector by code
   output logic level // terminal level
);
   import dom_pkg::*;
   logic state;
   always_comb begin
      state = 1'b0;
      case (fn_code)
         dom_fn_run, dom_fn_arrival_constant_speed, dom_fn_arrival_over_frequency,
         dom_fn_overload_warning, dom_fn_pid_deviation, dom_fn_alarm,
         dom_fn_arrival_at_threshold, dom_fn_power_loss, dom_fn_undervoltage,
         dom_fn_run_time_over, dom_fn_powered_time_over: state = cond[fn_code[3:0]]; // R2
         dom_fn_thermal: state = allow_thermal & cond[fn_code[3:0]]; // R2
         default: state = 1'b0; // R20
      endcase
   end
   // closed sense inverts the state
   assign level = state ^ (polarity == dom_pol_closed); // R4 R21
endmodule // dom_out_sel

/* hdl/dom_mon_sel.sv */
`timescale 1ns/100ps
module dom_mon_sel (
   input wire logic [7:0] sel, // monitor select code
   input wire logic digital_ok, // output may carry digital frequency
   input wire dom_pkg::dom_meas_t meas, // measured quantities
   output dom_pkg::dom_mon_t mon // selected quantity
);
   import dom_pkg::*;
   always_comb begin
      mon = '0;
      mon.valid = 1'b1;
      case (sel)
         dom_mon_freq: mon.value = meas.out_freq; // R3
         dom_mon_current: mon.value = meas.out_current;
         dom_mon_digital_freq: begin
            mon.value = digital_ok ? meas.out_freq : '0;
            mon.valid = digital_ok;
         end
         dom_mon_voltage: mon.value = meas.out_voltage;
         dom_mon_power: mon.value = meas.in_power;
         dom_mon_thermal: mon.value = meas.thermal_level;
         dom_mon_ramp_freq: mon.value = meas.ramp_freq;
         default: mon.valid = 1'b0;
      endcase
   end
endmodule // dom_mon_sel

/* hdl/dom_mux.sv */
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module dom_mux #(
   parameter bit thermal_variant = 1'b1 // twelfth code available
) (
   input wire logic clock, // 100 MHz control clock
   input wire logic sys_rst, // async reset, high
   input wire logic clk_en, // freezes state when low
   input wire logic [dom_pkg::dom_aw-1:0] reg_addr, // register index
   input wire logic [dom_pkg::dom_dw-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [dom_pkg::dom_dw-1:0] reg_rdata, // read data, next cycle
   input wire dom_pkg::dom_status_t status, // drive conditions, same clock
   input wire dom_pkg::dom_meas_t meas, // measured quantities
   input wire logic alarm_raw, // external trip pin, async
   output logic logic_out_a, // terminal a level
   output logic logic_out_b, // terminal b level
   output logic relay_out, // alarm relay level
   output dom_pkg::dom_mon_t pulse_monitor_out, // pulse monitor quantity
   output dom_pkg::dom_mon_t voltage_monitor_out, // voltage monitor quantity
   output dom_pkg::dom_mon_t current_monitor_out // current monitor quantity
);
   import dom_pkg::*;

   logic [7:0] logic_out_a_function;
   logic [7:0] logic_out_b_function;
   logic [7:0] relay_out_function;
   logic [7:0] pulse_monitor_select;
   logic [7:0] voltage_monitor_select;
   logic [7:0] current_monitor_select;
   logic [7:0] logic_out_a_polarity;
   logic [7:0] logic_out_b_polarity;
   logic [7:0] relay_out_polarity;
   logic [15:0] accel_arrival_threshold;
   logic [15:0] decel_arrival_threshold;
   logic [15:0] deviation_threshold;
   logic alarm_flag;
   logic over_freq_state;
   logic [2:0] alarm_sync;
   logic alarm_pin;
   logic [13:0] cond;
   logic next_level_a;
   logic next_level_b;
   logic next_level_r;
   dom_mon_t next_pulse;
   dom_mon_t next_volt;
   dom_mon_t next_curr;

   function automatic logic hit(input logic [3:0] idx);
      hit = reg_wr && (reg_addr == idx);
   endfunction

   // register writes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         logic_out_a_function <= dom_rst_out_a_fn; // R1
         logic_out_b_function <= dom_rst_out_b_fn; // R1
         relay_out_function <= dom_rst_relay_fn; // R1
         pulse_monitor_select <= dom_rst_mon_sel; // R3
         voltage_monitor_select <= dom_rst_mon_sel; // R3
         current_monitor_select <= dom_rst_mon_sel; // R3
         logic_out_a_polarity <= dom_pol_open; // R5
         logic_out_b_polarity <= dom_pol_open; // R5
         relay_out_polarity <= dom_pol_closed; // R6
         accel_arrival_threshold <= dom_rst_arrival; // R19
         decel_arrival_threshold <= dom_rst_arrival; // R19
         deviation_threshold <= dom_rst_dev_thr; // R18
      end else if (clk_en) begin
         if (hit(dom_reg_out_a_fn)) logic_out_a_function <= reg_wdata[7:0];
         if (hit(dom_reg_out_b_fn)) logic_out_b_function <= reg_wdata[7:0];
         if (hit(dom_reg_relay_fn)) relay_out_function <= reg_wdata[7:0];
         if (hit(dom_reg_pulse_sel)) pulse_monitor_select <= reg_wdata[7:0];
         if (hit(dom_reg_volt_sel)) voltage_monitor_select <= reg_wdata[7:0];
         if (hit(dom_reg_curr_sel)) current_monitor_select <= reg_wdata[7:0];
         if (hit(dom_reg_out_a_pol)) logic_out_a_polarity <= reg_wdata[7:0];
         if (hit(dom_reg_out_b_pol)) logic_out_b_polarity <= reg_wdata[7:0];
         if (hit(dom_reg_relay_pol)) relay_out_polarity <= reg_wdata[7:0];
         if (hit(dom_reg_accel_thr)) accel_arrival_threshold <= reg_wdata;
         if (hit(dom_reg_decel_thr)) decel_arrival_threshold <= reg_wdata;
         // out-of-range writes clamp rather than wrap
         if (hit(dom_reg_dev_thr)) begin
            deviation_threshold <= (reg_wdata > dom_dev_thr_max) ?
               dom_dev_thr_max : reg_wdata; // R18
         end
      end
   end

   // register reads; unmapped reads return zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         reg_rdata <= '0;
         if (reg_rd) begin
            case (reg_addr)
               dom_reg_out_a_fn: reg_rdata <= {8'h00, logic_out_a_function};
               dom_reg_out_b_fn: reg_rdata <= {8'h00, logic_out_b_function};
               dom_reg_relay_fn: reg_rdata <= {8'h00, relay_out_function};
               dom_reg_pulse_sel: reg_rdata <= {8'h00, pulse_monitor_select};
               dom_reg_volt_sel: reg_rdata <= {8'h00, voltage_monitor_select};
               dom_reg_curr_sel: reg_rdata <= {8'h00, current_monitor_select};
               dom_reg_out_a_pol: reg_rdata <= {8'h00, logic_out_a_polarity};
               dom_reg_out_b_pol: reg_rdata <= {8'h00, logic_out_b_polarity};
               dom_reg_relay_pol: reg_rdata <= {8'h00, relay_out_polarity};
               dom_reg_accel_thr: reg_rdata <= accel_arrival_threshold;
               dom_reg_decel_thr: reg_rdata <= decel_arrival_threshold;
               dom_reg_dev_thr: reg_rdata <= deviation_threshold;
               dom_reg_status: reg_rdata <= {9'h000, relay_out, logic_out_b,
                  logic_out_a, over_freq_state, alarm_flag, cond[0], cond[1]};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // trip pin crosses in; only second and third stage are compared
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         alarm_sync <= 3'h0;
         alarm_pin <= 1'b0;
      end else if (clk_en) begin
         alarm_sync <= {alarm_sync[1:0], alarm_raw};
         if (alarm_sync[2] == alarm_sync[1]) alarm_pin <= alarm_sync[2];
      end
   end

   // alarm latch: a new trip beats a simultaneous reset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         alarm_flag <= 1'b0; // R14
      end else if (clk_en) begin
         if (status.alarm_event || alarm_pin) alarm_flag <= 1'b1; // R13
         else if (status.alarm_reset) alarm_flag <= 1'b0; // R13 R14
      end
   end

   // over-frequency hysteresis between accel and decel thresholds
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         over_freq_state <= 1'b0;
      end else if (clk_en) begin
         if (status.accelerating && meas.out_freq >= accel_arrival_threshold)
            over_freq_state <= 1'b1; // R9
         else if (status.decelerating && meas.out_freq < decel_arrival_threshold)
            over_freq_state <= 1'b0; // R9
      end
   end

   always_comb begin
      cond = '0;
      cond[dom_fn_run[3:0]] = status.running; // R7
      cond[dom_fn_arrival_constant_speed[3:0]] =
         status.running && (meas.out_freq == meas.set_frequency); // R8
      cond[dom_fn_arrival_over_frequency[3:0]] = over_freq_state; // R9
      cond[dom_fn_overload_warning[3:0]] = status.overload_warning; // R11
      cond[dom_fn_pid_deviation[3:0]] = meas.pid_error > deviation_threshold; // R12
      cond[dom_fn_alarm[3:0]] = alarm_flag; // R13
      cond[dom_fn_arrival_at_threshold[3:0]] =
         (status.accelerating && meas.out_freq == accel_arrival_threshold) ||
         (status.decelerating && meas.out_freq == decel_arrival_threshold); // R10
      cond[dom_fn_power_loss[3:0]] = status.power_loss_flag; // R15
      cond[dom_fn_undervoltage[3:0]] = status.undervoltage_flag; // R15
      cond[dom_fn_run_time_over[3:0]] = status.run_time_over; // R16
      cond[dom_fn_powered_time_over[3:0]] = status.powered_time_over; // R17
      cond[dom_fn_thermal[3:0]] = status.thermal_over;
   end

   dom_out_sel u_sel_a (
      .fn_code(logic_out_a_function),
      .polarity(logic_out_a_polarity),
      .allow_thermal(thermal_variant),
      .cond(cond),
      .level(next_level_a)
   );
   dom_out_sel u_sel_b (
      .fn_code(logic_out_b_function),
      .polarity(logic_out_b_polarity),
      .allow_thermal(thermal_variant),
      .cond(cond),
      .level(next_level_b)
   );
   dom_out_sel u_sel_r (
      .fn_code(relay_out_function),
      .polarity(relay_out_polarity),
      .allow_thermal(thermal_variant),
      .cond(cond),
      .level(next_level_r)
   );

   dom_mon_sel u_mon_p (
      .sel(pulse_monitor_select),
      .digital_ok(1'b1),
      .meas(meas),
      .mon(next_pulse)
   );
   dom_mon_sel u_mon_v (
      .sel(voltage_monitor_select),
      .digital_ok(1'b0),
      .meas(meas),
      .mon(next_volt)
   );
   dom_mon_sel u_mon_c (
      .sel(current_monitor_select),
      .digital_ok(1'b0),
      .meas(meas),
      .mon(next_curr)
   );

   // terminal levels registered each control cycle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         logic_out_a <= 1'b0;
         logic_out_b <= 1'b0;
         relay_out <= 1'b1; // closed sense, no alarm
      end else if (clk_en) begin
         logic_out_a <= next_level_a; // R21
         logic_out_b <= next_level_b; // R21
         relay_out <= next_level_r; // R21
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_monitor_out <= '0;
         voltage_monitor_out <= '0;
         current_monitor_out <= '0;
      end else if (clk_en) begin
         pulse_monitor_out <= next_pulse; // R3
         voltage_monitor_out <= next_volt; // R3
         current_monitor_out <= next_curr; // R3
      end
   end

   property p_run_out;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && logic_out_b_function == dom_fn_run && logic_out_b_polarity == dom_pol_open)
      |=> (logic_out_b == $past(status.running));
   endproperty
   a_run_out: assert property (p_run_out) else $error("run output wrong"); // R7

   property p_alarm_hold;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && alarm_flag && !status.alarm_reset) |=> alarm_flag;
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm dropped"); // R13

   property p_alarm_set;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && status.alarm_event) |=> alarm_flag;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm not latched"); // R13

   property p_alarm_clear;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && status.alarm_reset && !status.alarm_event && !alarm_pin) |=> !alarm_flag;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear) else $error("alarm not cleared"); // R14

   property p_relay_pol;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && relay_out_function == dom_fn_alarm && relay_out_polarity == dom_pol_closed)
      |=> (relay_out == !$past(alarm_flag));
   endproperty
   a_relay_pol: assert property (p_relay_pol) else $error("relay sense wrong"); // R4

   property p_reserved;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && (logic_out_a_function == 8'h07 || logic_out_a_function == 8'h0a)
         && logic_out_a_polarity == dom_pol_open) |=> !logic_out_a;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code active"); // R20

   property p_dev;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && logic_out_a_function == dom_fn_pid_deviation
         && logic_out_a_polarity == dom_pol_open)
      |=> (logic_out_a == ($past(meas.pid_error) > $past(deviation_threshold)));
   endproperty
   a_dev: assert property (p_dev) else $error("deviation output wrong"); // R12

   property p_dev_max;
      @(posedge clock) disable iff (sys_rst)
      deviation_threshold <= dom_dev_thr_max;
   endproperty
   a_dev_max: assert property (p_dev_max) else $error("deviation over range"); // R18

   property p_overfreq;
      @(posedge clock) disable iff (sys_rst)
      (clk_en && status.accelerating && meas.out_freq >= accel_arrival_threshold)
      |=> over_freq_state;
   endproperty
   a_overfreq: assert property (p_overfreq) else $error("over-frequency missed"); // R9

   c_alarm: cover property (@(posedge clock) disable iff (sys_rst) $rose(alarm_flag));
   c_overfreq: cover property (@(posedge clock) disable iff (sys_rst) $fell(over_freq_state));
   c_relay: cover property (@(posedge clock) disable iff (sys_rst) $fell(relay_out));
endmodule // dom_mux

/* verification/dom_load_model.sv */
`timescale 1ns/100ps
module dom_load_model (
   input wire logic clock, // control clock
   input wire logic logic_out_a, // terminal a level
   input wire logic logic_out_b, // terminal b level
   input wire logic relay_out, // relay level
   output logic lamp_a, // lamp a lit
   output logic lamp_b, // lamp b lit
   output logic coil_on // relay coil energised
);
   // contacts follow the drive a cycle late, like a real coil pulling in
   always_ff @(posedge clock) begin
      lamp_a <= logic_out_a;
      lamp_b <= logic_out_b;
      coil_on <= relay_out;
   end
endmodule // dom_load_model

/* verification/drive_output_function_mux_tb_top.sv */
`timescale 1ns/100ps
module drive_output_function_mux_tb_top;
   import dom_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   dom_status_t status = '0;
   dom_meas_t meas = '0;
   logic alarm_raw = 1'b0;
   logic out_a, out_b, relay, lamp_a, lamp_b, coil_on;
   dom_mon_t mon_p, mon_v, mon_c;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   logic [15:0] acc_thr = 16'h0065;
   logic [15:0] dec_thr = 16'h0066;
   logic [15:0] rst_tab [12] = '{16'h01, 16'h00, 16'h05, 16'h00, 16'h00, 16'h00, 16'h00,
      16'h00, 16'h01, 16'h0000, 16'h0000, 16'h001e};
   logic [7:0] codes [13] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c,
      8'h0d, 8'h07, 8'h0a, 8'h0e};
   logic [7:0] mcodes [8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h02};
   always #5 clock = ~clock;
   dom_mux uut (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .status(status), .meas(meas), .alarm_raw(alarm_raw), .logic_out_a(out_a),
      .logic_out_b(out_b), .relay_out(relay), .pulse_monitor_out(mon_p),
      .voltage_monitor_out(mon_v), .current_monitor_out(mon_c));
   dom_load_model load (.clock(clock), .logic_out_a(out_a), .logic_out_b(out_b),
      .relay_out(relay), .lamp_a(lamp_a), .lamp_b(lamp_b), .coil_on(coil_on));
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         err_total++;
         $display("unexpected at %0t: run hung", $time);
         stop_test();
      end
   end
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({15'h0000, got}, {15'h0000, exp}, what);
   endtask
   task automatic chk_mon(input dom_mon_t got, input dom_mon_t exp, input string what);
      chk_word(got.value, exp.value, what);
      chk_bit(got.valid, exp.valid, what);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // expected function state from the conditions the bench drives
   function automatic logic exp_state(input logic [7:0] c, input dom_status_t s,
      input dom_meas_t m);
      case (c)
         dom_fn_run: return s.running;
         dom_fn_arrival_constant_speed: return s.running && m.out_freq == m.set_frequency;
         dom_fn_overload_warning: return s.overload_warning;
         dom_fn_pid_deviation: return m.pid_error > dom_rst_dev_thr;
         dom_fn_arrival_at_threshold: return (s.accelerating && m.out_freq == acc_thr) ||
            (s.decelerating && m.out_freq == dec_thr);
         dom_fn_power_loss: return s.power_loss_flag;
         dom_fn_undervoltage: return s.undervoltage_flag;
         dom_fn_run_time_over: return s.run_time_over;
         dom_fn_powered_time_over: return s.powered_time_over;
         dom_fn_thermal: return s.thermal_over;
         default: return 1'b0;
      endcase
   endfunction
   function automatic dom_mon_t exp_mon(input logic [7:0] c, input logic pulse);
      case (c)
         dom_mon_freq: return {meas.out_freq, 1'b1};
         dom_mon_current: return {meas.out_current, 1'b1};
         dom_mon_digital_freq: return pulse ? {meas.out_freq, 1'b1} : 17'h00000;
         dom_mon_voltage: return {meas.out_voltage, 1'b1};
         dom_mon_power: return {meas.in_power, 1'b1};
         dom_mon_thermal: return {meas.thermal_level, 1'b1};
         dom_mon_ramp_freq: return {meas.ramp_freq, 1'b1};
         default: return 17'h00000;
      endcase
   endfunction
   task automatic alarm_cycle(input bit use_pin);
      @(posedge clock);
      if (use_pin) alarm_raw <= 1'b1;
      else status.alarm_event <= 1'b1;
      repeat (4) @(posedge clock);
      alarm_raw <= 1'b0;
      status.alarm_event <= 1'b0;
      wait_n(8);
      chk_bit(relay, 1'b0, "alarm latched");
      @(posedge clock);
      status.alarm_reset <= 1'b1;
      @(posedge clock);
      status.alarm_reset <= 1'b0;
      wait_n(3);
      chk_bit(relay, 1'b1, "alarm cleared");
   endtask
   initial begin
      logic [15:0] d;
      logic [7:0] fa, fb, fr, pa, pb, pr;
      dom_status_t s;
      dom_meas_t m;
      // first step decelerates below the decel threshold, clearing any latch left by random tests
      logic [2:0] st_acc [4] = '{3'b001, 3'b110, 3'b101, 3'b001};
      logic [15:0] st_freq [4] = '{16'h0064, 16'h0065, 16'h0066, 16'h0065};
      void'($urandom(32'h08e1e4e9));
      wait_n(5);
      chk_bit(relay, 1'b1, "relay in reset");
      @(posedge clock);
      sys_rst <= 1'b0;
      wait_n(2);
      chk_bit(out_a, 1'b0, "a after reset");
      chk_bit(out_b, 1'b0, "b after reset");
      chk_bit(relay, 1'b1, "relay after reset");
      chk_mon(mon_c, {16'h0000, 1'b1}, "monitor after reset");
      for (int i = 0; i < 12; i++) begin
         rd_reg(4'(i), d);
         chk_word(d, rst_tab[i], "reset value");
      end
      wr_reg(4'hd, 16'h00ff);
      rd_reg(4'hd, d);
      chk_word(d, 16'h0000, "unmapped index");
      wr_reg(dom_reg_dev_thr, 16'h1000);
      rd_reg(dom_reg_dev_thr, d);
      chk_word(d, dom_dev_thr_max, "deviation clamp");
      wr_reg(dom_reg_dev_thr, dom_rst_dev_thr);
      wr_reg(dom_reg_accel_thr, acc_thr);
      wr_reg(dom_reg_decel_thr, dec_thr);
      $display("test registers done");
      for (int i = 0; i < 200; i++) begin
         fa = codes[$urandom % 13];
         fb = codes[$urandom % 13];
         fr = codes[$urandom % 13];
         pa = 8'($urandom % 3);
         pb = 8'($urandom % 3);
         pr = 8'($urandom % 3);
         wr_reg(dom_reg_out_a_fn, {8'h00, fa});
         wr_reg(dom_reg_out_b_fn, {8'h00, fb});
         wr_reg(dom_reg_relay_fn, {8'h00, fr});
         wr_reg(dom_reg_out_a_pol, {8'h00, pa});
         wr_reg(dom_reg_out_b_pol, {8'h00, pb});
         wr_reg(dom_reg_relay_pol, {8'h00, pr});
         s = dom_status_t'(11'($urandom));
         s.alarm_event = 1'b0;
         s.alarm_reset = 1'b0;
         m = {$urandom, $urandom, $urandom, $urandom};
         m.out_freq = 16'h0064 + 16'($urandom % 4);
         m.set_frequency = 16'h0064 + 16'($urandom % 4);
         m.pid_error = 16'h001c + 16'($urandom % 4);
         @(posedge clock);
         status <= s;
         meas <= m;
         wait_n(3);
         chk_bit(out_a, exp_state(fa, s, m) ^ (pa == 8'h01), "terminal a");
         chk_bit(out_b, exp_state(fb, s, m) ^ (pb == 8'h01), "terminal b");
         chk_bit(relay, exp_state(fr, s, m) ^ (pr == 8'h01), "relay");
         chk_bit(coil_on, exp_state(fr, s, m) ^ (pr == 8'h01), "relay coil");
      end
      $display("test random functions done");
      wr_reg(dom_reg_out_a_fn, {8'h00, dom_fn_arrival_over_frequency});
      wr_reg(dom_reg_out_a_pol, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         status <= '0;
         status.accelerating <= st_acc[i][1];
         status.decelerating <= st_acc[i][0];
         meas.out_freq <= st_freq[i];
         wait_n(3);
         chk_bit(out_a, st_acc[i][2], "over frequency latch");
      end
      $display("test over frequency done");
      @(posedge clock);
      status <= '0;
      wr_reg(dom_reg_relay_fn, {8'h00, dom_fn_alarm});
      wr_reg(dom_reg_relay_pol, {8'h00, dom_pol_closed});
      wait_n(3);
      chk_bit(relay, 1'b1, "no trip");
      alarm_cycle(1'b0);
      alarm_cycle(1'b1);
      $display("test alarm done");
      @(posedge clock);
      meas <= {16'h1111, 16'h2222, 16'h0003, 16'h4444, 16'h5555, 16'h6666, 16'h7777, 16'h8888};
      for (int i = 0; i < 8; i++) begin
         wr_reg(dom_reg_pulse_sel, {8'h00, mcodes[i]});
         wr_reg(dom_reg_volt_sel, {8'h00, mcodes[i]});
         wr_reg(dom_reg_curr_sel, {8'h00, mcodes[i]});
         wait_n(3);
         chk_mon(mon_p, exp_mon(mcodes[i], 1'b1), "pulse monitor");
         chk_mon(mon_v, exp_mon(mcodes[i], 1'b0), "voltage monitor");
         chk_mon(mon_c, exp_mon(mcodes[i], 1'b0), "current monitor");
      end
      $display("test monitors done");
      stop_test();
   end
endmodule // drive_output_function_mux_tb_top
